// *** inc/cell_pkg.sv ***
package cell_pkg;

    // ------------------------------------------------------------
    // Register map (byte addresses on the AHB-Lite slave)
    // ------------------------------------------------------------
    localparam logic [7:0]  CFG_OFS   = 8'h00;   // Mode and routing selections
    localparam logic [7:0]  MASK_OFS  = 8'h04;   // Lookup table contents
    localparam logic [7:0]  CTRL_OFS  = 8'h08;   // Run control
    localparam logic [7:0]  STAT_OFS  = 8'h0C;   // Live cell state, read only

    // ------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------
    localparam int          CFG_W     = 11;      // Width of the packed configuration
    localparam int          MASK_W    = 16;      // Four-input table, 16 entries
    localparam int          HALF_W    = 8;       // Three-input table, 8 entries
    localparam int          RUN_BIT   = 0;       // Position of run in the control word
    localparam int          STAT_W    = 7;       // Width of the packed status

    // Operating modes of the cell
    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_ARITH,
        MODE_COUNT
    } cell_mode_e;

    // What loads the cell register in normal mode
    typedef enum logic [1:0] {
        SRC_LUT,
        SRC_FOURTH,
        SRC_PICK
    } reg_src_e;

    // Static configuration word, LSB last
    typedef struct packed {
        logic       global_sel;   // 1: register drives global routing
        logic       local_sel;    // 1: register drives local routing
        logic [1:0] pick;         // Table input that is also registered
        reg_src_e   reg_src;      // Register source in normal mode
        logic       cascade_or;   // 1: OR cascade, 0: AND cascade
        logic       cascade_en;   // Merge incoming cascade
        logic       carry_sel;    // 1: carry-in replaces third input
        cell_mode_e mode;
    } cfg_s;

    // Observable cell state
    typedef struct packed {
        logic run;
        logic global_out;
        logic local_out;
        logic cascade_out;
        logic carry_out;
        logic lut_out;
        logic reg_q;
    } stat_s;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam cfg_s              CFG_RST  = '0;
    localparam logic [MASK_W-1:0] MASK_RST = 16'h0000;
    localparam logic              RUN_RST  = 1'b0;

    // AHB-Lite encodings
    localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
    localparam logic        HRESP_OKAY    = 1'b0;

endpackage

// *** rtl/logic_cell.sv ***
`timescale 1ns/1ps
// Functional notes
// - Normal mode: four local inputs plus carry-in feed a four-input table.
// - Normal mode: carry-in or third input is table input, fixed by configuration.
// - Outside counter mode, table result merges with cascade-in to form cascade-out.
// - Register or table may drive local and global routing together.
// - Separate local and global outputs let table and register work apart.
// - Fourth input loads the register while table computes three-input function.
// - Alternatively a four-input function runs while one of its inputs registers.
// - Packed register still honours clock enable, clear and preset.
// - Packed cell: register to global with table local, or reverse.
// - Arithmetic mode splits into two three-input tables: result and carry.
// - First arithmetic table uses carry-in and two inputs; output plain or registered.
// - Second table uses same signals to make carry-out for the chain.
// - Arithmetic mode may use the cascade chain at the same time.
// - Counter mode offers count enable, clock enable, direction and loading.
// - Counter controls come from inputs, carry-in and register feedback.
// - Counter uses two three-input tables: next count bit and fast carry.
// - Two-input selector before register gives synchronous load.
// - Clear and preset load the counter asynchronously, without table use.
module logic_cell
    import cell_pkg::*;
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    // Cell pins
    input  wire logic [3:0]  cell_in,
    input  wire logic        carry_in,
    input  wire logic        cascade_in,
    input  wire logic        cell_clk_en,
    input  wire logic        cell_clear,
    input  wire logic        cell_preset,
    output logic             carry_out,
    output logic             cascade_out,
    output logic             local_out,
    output logic             global_out
);

    // ------------------------------------------------------------
    // Table lookup helpers
    // ------------------------------------------------------------
    // Plain index into a table; the caller decides which inputs form the index
    function automatic logic lut3(input logic [HALF_W-1:0] tbl, input logic [2:0] idx);
        lut3 = tbl[idx];
    endfunction

    function automatic logic lut4(input logic [MASK_W-1:0] tbl, input logic [3:0] idx);
        lut4 = tbl[idx];
    endfunction

    // ------------------------------------------------------------
    // Bus slave state
    // ------------------------------------------------------------
    cfg_s              cfg_r,    cfg_nxt;
    logic [MASK_W-1:0] mask_r,   mask_nxt;
    logic              run_r,    run_nxt;
    logic              wr_pend_r, wr_pend_nxt;
    logic [7:0]        wr_addr_r, wr_addr_nxt;
    logic [31:0]       rdata_r,  rdata_nxt;
    logic              addr_phase;
    stat_s             stat;

    // Cell datapath
    logic              reg_q_r,  reg_q_nxt;
    logic [3:0]        lut_idx;
    logic              lut_res;
    logic              comb_res;
    logic              carry_res;
    logic              reg_d;
    logic              cnt_bit;

    // Zero wait states: the bus answer is fixed, only read data is registered
    assign hreadyout = 1'b1;                  // Every access completes in one data phase
    assign hresp     = HRESP_OKAY;
    assign hrdata    = rdata_r;
    assign addr_phase = hsel && hready && (htrans == HTRANS_NONSEQ);

    // ------------------------------------------------------------
    // Register file next state
    // ------------------------------------------------------------
    // Writes land in the data phase; reads are captured at the address
    // phase so hrdata comes straight from a flop.
    // The transfer size is ignored: every register is one whole aligned word.
    always_comb begin
        cfg_nxt     = cfg_r;
        mask_nxt    = mask_r;
        run_nxt     = run_r;
        wr_pend_nxt = addr_phase && hwrite;
        wr_addr_nxt = addr_phase ? haddr : wr_addr_r;
        rdata_nxt   = rdata_r;
        if (wr_pend_r) begin
            case (wr_addr_r)
                // Shape of the cell is frozen while it runs
                CFG_OFS:  if (!run_r) cfg_nxt = cfg_s'(hwdata[CFG_W-1:0]);
                MASK_OFS: if (!run_r) mask_nxt = hwdata[MASK_W-1:0];
                CTRL_OFS: run_nxt = hwdata[RUN_BIT];
                default:  ;
            endcase
        end
        if (addr_phase && !hwrite) begin
            case (haddr)
                CFG_OFS:  rdata_nxt = {21'h000000, cfg_r};
                MASK_OFS: rdata_nxt = {16'h0000, mask_r};
                CTRL_OFS: rdata_nxt = {31'h00000000, run_r};
                STAT_OFS: rdata_nxt = {25'h0000000, stat};
                default:  rdata_nxt = 32'h00000000;    // Unmapped reads as zero
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cfg_r     <= CFG_RST;
            mask_r    <= MASK_RST;
            run_r     <= RUN_RST;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            rdata_r   <= 32'h00000000;
        end else begin
            cfg_r     <= cfg_nxt;
            mask_r    <= mask_nxt;
            run_r     <= run_nxt;
            wr_pend_r <= wr_pend_nxt;
            wr_addr_r <= wr_addr_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // Table and chain logic
    // ------------------------------------------------------------
    // Normal mode swaps the third input for carry-in when asked.
    // Arithmetic and counter modes split the mask into two halves.
    always_comb begin
        lut_idx   = {cell_in[3], cfg_r.carry_sel ? carry_in : cell_in[2],
                     cell_in[1], cell_in[0]};
        lut_res   = 1'b0;
        carry_res = 1'b0;
        cnt_bit   = 1'b0;
        case (cfg_r.mode)
            MODE_ARITH: begin
                lut_res   = lut3(mask_r[HALF_W-1:0],
                                 {cell_in[1], cell_in[0], carry_in});
                carry_res = lut3(mask_r[MASK_W-1:HALF_W],
                                 {cell_in[1], cell_in[0], carry_in});
            end
            MODE_COUNT: begin
                // Direction on input 1, feedback from the register itself
                cnt_bit   = lut3(mask_r[HALF_W-1:0],
                                 {cell_in[1], reg_q_r, carry_in});
                carry_res = lut3(mask_r[MASK_W-1:HALF_W],
                                 {cell_in[1], reg_q_r, carry_in});
                lut_res   = cnt_bit;
            end
            default: begin
                // Fourth input routed to the register: table sees only three
                if (cfg_r.reg_src == SRC_FOURTH)
                    lut_res = lut4(mask_r, {1'b0, lut_idx[2:0]});
                else
                    lut_res = lut4(mask_r, lut_idx);
            end
        endcase
    end

    // Cascade merge is available in every mode except counting
    always_comb begin
        if (cfg_r.cascade_en && cfg_r.mode != MODE_COUNT)
            comb_res = cfg_r.cascade_or ? (lut_res | cascade_in)
                                        : (lut_res & cascade_in);
        else
            comb_res = lut_res;
    end

    assign cascade_out = comb_res;
    assign carry_out   = carry_res;

    // ------------------------------------------------------------
    // Register input selection
    // ------------------------------------------------------------
    always_comb begin
        reg_d = comb_res;
        case (cfg_r.mode)
            MODE_COUNT: begin
                // Input 3 is synchronous load, input 0 load data, input 2 count enable
                if (cell_in[3])
                    reg_d = cell_in[0];
                else if (cell_in[2])
                    reg_d = cnt_bit;
                else
                    reg_d = reg_q_r;
            end
            MODE_ARITH: reg_d = comb_res;
            default: begin
                // Normal mode, and the spare mode code, which behaves the same way
                case (cfg_r.reg_src)
                    SRC_FOURTH: reg_d = cell_in[3];
                    SRC_PICK:   reg_d = lut_idx[cfg_r.pick];
                    default:    reg_d = comb_res;
                endcase
            end
        endcase
        reg_q_nxt = cell_clk_en ? reg_d : reg_q_r;
    end

    // Clear and preset act at once and load constants; clear wins over preset.
    // Limitation: when one control falls while the other is still high, the
    // survivor only takes effect at the next clock edge.
    always_ff @(posedge hclk or negedge hresetn or posedge cell_clear or posedge cell_preset) begin
        if (!hresetn)
            reg_q_r <= 1'b0;
        else if (cell_clear)
            reg_q_r <= 1'b0;
        else if (cell_preset)
            reg_q_r <= 1'b1;
        else
            reg_q_r <= reg_q_nxt;
    end

    // ------------------------------------------------------------
    // Output routing
    // ------------------------------------------------------------
    // Two independent selectors let the register and the table share or split;
    // a packed cell sends the register one way and the table the other
    assign local_out  = cfg_r.local_sel  ? reg_q_r : comb_res;
    assign global_out = cfg_r.global_sel ? reg_q_r : comb_res;

    // Live state for software, in the layout of the status word
    assign stat = '{run:         run_r,
                    global_out:  global_out,
                    local_out:   local_out,
                    cascade_out: cascade_out,
                    carry_out:   carry_out,
                    lut_out:     lut_res,
                    reg_q:       reg_q_r};

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    // Register free to take its data input on this edge
    sequence s_reg_free;
        cell_clk_en && !cell_clear && !cell_preset;
    endsequence

    // Address phase of a configuration write followed by its data phase
    sequence s_cfg_write;
        addr_phase && hwrite && haddr == CFG_OFS ##1 1'b1;
    endsequence

    // Table contents are frozen while running, like the configuration
    sequence s_mask_write;
        addr_phase && hwrite && haddr == MASK_OFS ##1 1'b1;
    endsequence

    chk_carry_swap: assert property (
        cfg_r.mode == MODE_NORMAL && cfg_r.carry_sel && !cfg_r.cascade_en
        && cfg_r.reg_src == SRC_LUT
        |-> comb_res == mask_r[{cell_in[3], carry_in, cell_in[1], cell_in[0]}])
        else $error("normal table ignores carry-in selection");

    chk_cascade_and: assert property (
        cfg_r.mode != MODE_COUNT && cfg_r.cascade_en && !cfg_r.cascade_or && !cascade_in
        |-> !cascade_out)
        else $error("and cascade passed a high result");

    chk_route_split: assert property (
        cfg_r.local_sel != cfg_r.global_sel
        |-> (local_out == (cfg_r.local_sel ? reg_q_r : cascade_out))
            && (global_out == (cfg_r.global_sel ? reg_q_r : cascade_out)))
        else $error("packed routing split wrong");

    chk_fourth_load: assert property (
        ((cfg_r.mode == MODE_NORMAL && cfg_r.reg_src == SRC_FOURTH) and s_reg_free)
        ##1 !cell_clear && !cell_preset
        |-> reg_q_r == $past(cell_in[3]))
        else $error("fourth input not registered");

    chk_clk_en_hold: assert property (
        !cell_clk_en && !cell_clear && !cell_preset ##1 !cell_clear && !cell_preset
        |-> $stable(reg_q_r))
        else $error("register moved without clock enable");

    chk_arith_carry: assert property (
        cfg_r.mode == MODE_ARITH
        |-> carry_out == mask_r[{1'b1, cell_in[1], cell_in[0], carry_in}])
        else $error("arithmetic carry out wrong");

    chk_count_load: assert property (
        ((cfg_r.mode == MODE_COUNT && cell_in[3]) and s_reg_free)
        ##1 !cell_clear && !cell_preset
        |-> reg_q_r == $past(cell_in[0]))
        else $error("synchronous load missed");

    chk_count_idle: assert property (
        ((cfg_r.mode == MODE_COUNT && !cell_in[3] && !cell_in[2]) and s_reg_free)
        ##1 !cell_clear && !cell_preset
        |-> $stable(reg_q_r))
        else $error("counter moved without count enable");

    chk_async_clear: assert property (
        cell_clear ##1 cell_clear |-> !reg_q_r)
        else $error("clear did not hold register low");

    // Run is judged in the data phase, where the write would land
    chk_cfg_frozen: assert property (
        s_cfg_write ##0 run_r |=> $stable(cfg_r))
        else $error("configuration changed while running");

    chk_mask_frozen: assert property (
        s_mask_write ##0 run_r |=> $stable(mask_r))
        else $error("table contents changed while running");

    chk_preset_high: assert property (
        cell_preset && !cell_clear ##1 cell_preset && !cell_clear |-> reg_q_r)
        else $error("preset did not hold register high");

    chk_pick_load: assert property (
        ((cfg_r.mode == MODE_NORMAL && cfg_r.reg_src == SRC_PICK && cfg_r.pick == 2'h2
          && cfg_r.carry_sel) and s_reg_free)
        ##1 !cell_clear && !cell_preset
        |-> reg_q_r == $past(carry_in))
        else $error("shared table input not registered");

    // Table outputs against the mask, indexed the way each mode defines it
    chk_normal_lut: assert property (
        cfg_r.mode == MODE_NORMAL && cfg_r.reg_src == SRC_LUT && !cfg_r.carry_sel
        && !cfg_r.cascade_en |-> cascade_out == mask_r[cell_in])
        else $error("normal table output wrong");

    chk_fourth_free: assert property (
        cfg_r.mode == MODE_NORMAL && cfg_r.reg_src == SRC_FOURTH && !cfg_r.cascade_en
        && !cfg_r.carry_sel |-> cascade_out == mask_r[{1'b0, cell_in[2:0]}])
        else $error("table used the registered fourth input");

    chk_cascade_or: assert property (
        cfg_r.mode != MODE_COUNT && cfg_r.cascade_en && cfg_r.cascade_or && cascade_in
        |-> cascade_out)
        else $error("or cascade dropped a high input");

    chk_arith_sum: assert property (
        cfg_r.mode == MODE_ARITH && !cfg_r.cascade_en
        |-> cascade_out == mask_r[{1'b0, cell_in[1], cell_in[0], carry_in}])
        else $error("arithmetic result wrong");

    chk_normal_carry: assert property (
        cfg_r.mode == MODE_NORMAL |-> !carry_out)
        else $error("carry out driven outside split modes");

    // Counter tables see the register itself as one index bit
    chk_count_bit: assert property (
        cfg_r.mode == MODE_COUNT
        |-> cascade_out == mask_r[{1'b0, cell_in[1], reg_q_r, carry_in}])
        else $error("count table output wrong");

    chk_count_carry: assert property (
        cfg_r.mode == MODE_COUNT
        |-> carry_out == mask_r[{1'b1, cell_in[1], reg_q_r, carry_in}])
        else $error("counter carry out wrong");

endmodule

// *** testbench/logic_cell_tb.sv ***
`timescale 1ns/1ps
`define CHK(nm, e, g) check(nm, e, g)
module logic_cell_tb import cell_pkg::*;;
    logic        hclk, hresetn, hsel, hwrite, cell_clk_en, cell_clear, cell_preset;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, seed;
    logic [3:0]  cell_in;
    logic        pa, pb, pc, q_m;
    wire  logic [31:0] hrdata;
    wire  logic  hreadyout, hresp, carry_in, cascade_in;
    wire  logic  carry_out, cascade_out, local_out, global_out;
    cfg_s        cur_cfg;
    logic [15:0] cur_mask;
    int          n_errors, check_count;

    // ------------------------------------------------------------
    // Instances
    // ------------------------------------------------------------
    logic_cell i_logic_cell (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cell_in(cell_in),
        .carry_in(carry_in), .cascade_in(cascade_in), .cell_clk_en(cell_clk_en),
        .cell_clear(cell_clear), .cell_preset(cell_preset), .carry_out(carry_out),
        .cascade_out(cascade_out), .local_out(local_out), .global_out(global_out));
    neighbour_cell i_neighbour_cell (.a(pa), .b(pb), .cin(pc), .carry_chain(carry_in),
        .cascade_chain(cascade_in));

    always #12.5 hclk = ~hclk;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected {global, local, cascade, carry} for the current inputs
    function automatic logic [3:0] exp_out(cfg_s c, logic [15:0] m, logic [3:0] d,
                                           logic ci, logic cc, logic q);
        logic l, cy, cs;
        case (c.mode)
            MODE_ARITH: begin
                l  = m[{1'b0, d[1], d[0], ci}];
                cy = m[{1'b1, d[1], d[0], ci}];
            end
            MODE_COUNT: begin
                l  = m[{1'b0, d[1], q, ci}];
                cy = m[{1'b1, d[1], q, ci}];
            end
            default: begin
                l  = m[{(c.reg_src == SRC_FOURTH) ? 1'b0 : d[3], c.carry_sel ? ci : d[2], d[1:0]}];
                cy = 1'b0;
            end
        endcase
        cs = (c.cascade_en && c.mode != MODE_COUNT) ? (c.cascade_or ? (l | cc) : (l & cc)) : l;
        return {c.global_sel ? q : cs, c.local_sel ? q : cs, cs, cy};
    endfunction

    // Next register value at an enabled edge; load beats count in counter mode
    function automatic logic next_q(cfg_s c, logic [15:0] m, logic [3:0] d,
                                    logic ci, logic cc, logic q);
        logic [3:0] o;
        o = exp_out(c, m, d, ci, cc, q);
        if (c.mode == MODE_COUNT)
            return d[3] ? d[0] : (d[2] ? m[{2'b00, d[1], q, ci}] : q);
        if (c.mode == MODE_ARITH)
            return o[1];
        if (c.reg_src == SRC_FOURTH)
            return d[3];
        if (c.reg_src == SRC_PICK)
            return (c.pick == 2'd2 && c.carry_sel) ? ci : d[c.pick];
        return o[1];
    endfunction

    // Model the cell register at the next rising edge, before new inputs land
    task automatic edge_model();
        @(posedge hclk);
        if (!cell_clear && !cell_preset && cell_clk_en)
            q_m = next_q(cur_cfg, cur_mask, cell_in, carry_in, cascade_in, q_m);
    endtask

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic stop_test();
        $display("errors %0d, checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Bounded wait for hready sampled high at a rising edge
    task automatic wait_ready();
        int n;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1) begin
            n_errors++;
            stop_test();
        end
    endtask

    // One single AHB-Lite word transfer
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr  <= a;
        hwrite <= wr;
        hsize  <= 3'h2;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
        `CHK("hresp", HRESP_OKAY, hresp);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        logic [31:0] x;
        ahb(1'b0, a, 32'h0, x);
        `CHK(nm, e, x);
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        ahb(1'b1, a, d, x);
    endtask

    task automatic set_cfg(input cfg_s c, input logic [15:0] m);
        edge_model();
        cell_clk_en <= 1'b0;    // Register must not move while the shape changes
        wr_reg(CFG_OFS, {21'h0, c});
        wr_reg(MASK_OFS, {16'h0, m});
        cur_cfg  = c;
        cur_mask = m;
    endtask

    // One cell cycle: update model at the edge, drive new inputs, check at mid-cycle
    task automatic cell_step(input logic ce, input logic pre, input logic clr);
        logic [31:0] r;
        logic [3:0]  e;
        edge_model();
        r = rnd();
        cell_in     <= r[3:0];
        pa          <= r[4];
        pb          <= r[5];
        pc          <= r[6];
        cell_clk_en <= ce;
        cell_preset <= pre;
        cell_clear  <= clr;
        @(negedge hclk);
        if (clr)
            q_m = 1'b0;
        else if (pre)
            q_m = 1'b1;
        e = exp_out(cur_cfg, cur_mask, cell_in, carry_in, cascade_in, q_m);
        `CHK("carry_out", e[0], carry_out);
        `CHK("cascade_out", e[1], cascade_out);
        `CHK("local_out", e[2], local_out);
        `CHK("global_out", e[3], global_out);
    endtask

    // Hang guard
    initial begin
        repeat (20000) @(posedge hclk);
        n_errors++;
        stop_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        cfg_s        c;
        logic [31:0] x;
        {hclk, hsel, hwrite, haddr, htrans, hsize, hwdata, cell_in, pa, pb, pc} = '0;
        {cell_clk_en, cell_preset, q_m, n_errors, check_count} = '0;
        cell_clear = 1'b1;
        hresetn    = 1'b0;
        seed       = 32'h2D862056;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        rd_chk("cfg_rst", CFG_OFS, 32'h0);
        rd_chk("mask_rst", MASK_OFS, 32'h0);
        rd_chk("ctrl_rst", CTRL_OFS, 32'h0);
        wr_reg(8'h10, 32'hFFFFFFFF);
        rd_chk("unmapped", 8'h10, 32'h0);
        wr_reg(CFG_OFS, 32'hFFFFF2A5);
        rd_chk("cfg", CFG_OFS, 32'h000002A5);
        wr_reg(MASK_OFS, 32'hABCD1234);
        rd_chk("mask", MASK_OFS, 32'h00001234);
        wr_reg(CTRL_OFS, 32'h1);
        wr_reg(CFG_OFS, 32'h0);
        wr_reg(MASK_OFS, 32'h0);
        rd_chk("cfg_frozen", CFG_OFS, 32'h000002A5);
        rd_chk("mask_frozen", MASK_OFS, 32'h00001234);
        ahb(1'b0, STAT_OFS, 32'h0, x);
        `CHK("stat_run", 1'b1, x[6]);
        wr_reg(CTRL_OFS, 32'h0);
        // Random modes and tables, register held clear so it never shows
        repeat (40) begin
            c = cfg_s'(rnd());
            c.local_sel  = 1'b0;
            c.global_sel = 1'b0;
            if (c.reg_src == 2'd3)
                c.reg_src = SRC_LUT;
            set_cfg(c, rnd());
            repeat (6) cell_step(1'b1, 1'b0, 1'b1);
        end
        // Packing: fourth input registered, register on local routing
        c = '0;
        c.reg_src   = SRC_FOURTH;
        c.local_sel = 1'b1;
        set_cfg(c, rnd());
        repeat (16) cell_step(rnd() % 2, 1'b0, 1'b0);
        // Packing: a table input registered, register on global routing
        c.reg_src    = SRC_PICK;
        c.local_sel  = 1'b0;
        c.global_sel = 1'b1;
        c.carry_sel  = 1'b1;
        c.pick       = 2'd2;
        set_cfg(c, rnd());
        repeat (16) cell_step(rnd() % 2, 1'b0, 1'b0);
        // Preset held, clear winning over preset, then clear alone; the controls
        // are let go one at a time since a survivor only acts at the next edge
        repeat (2) cell_step(1'b1, 1'b1, 1'b0);
        cell_step(1'b1, 1'b1, 1'b1);
        cell_step(1'b1, 1'b0, 1'b1);
        // Counter: toggle table and up/down carry table
        c = '0;
        c.mode      = MODE_COUNT;
        c.local_sel = 1'b1;
        set_cfg(c, 16'h2866);
        repeat (40) cell_step(rnd() % 4 != 0, 1'b0, 1'b0);
        stop_test();
    end
endmodule

// *** testbench/neighbour_cell.sv ***
`timescale 1ns/1ps
// ------------------------------------------------------------
// Upstream neighbour in the carry and cascade chains
// ------------------------------------------------------------
module neighbour_cell (
    input  wire logic a,
    input  wire logic b,
    input  wire logic cin,
    output logic      carry_chain,
    output logic      cascade_chain
);
    // Full-adder carry stage; no registers, so its outputs move with its inputs
    assign carry_chain   = (a & b) | (cin & (a ^ b));
    // Decoded term as a wide-decode chain would hand on (active low decode)
    assign cascade_chain = ~(a & cin);
endmodule
